// File: clock_stop_powerdown_control.sv
/*
  Clock stop and power-down control of a multi-output clock generator.
  Holds the shared power-good / power-down pin sequencing, host clock stop,
  bus clock stop and the parking of every output.
  Assumes the output clock phases arrive as same-domain levels from the
  generator core.
*/
`timescale 1ns/1ps
module clock_stop_powerdown_control
  import clkstop_pkg::*;
#(
  parameter int unsigned STABLE_CNT = STABLE_CYCLES,
  parameter int unsigned LOCK_CNT   = LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  // Power-management pins (asynchronous)
  input  wire logic                 powergood_powerdown_pin_in,
  input  wire logic                 host_clock_stop_n_in,
  input  wire logic                 bus_clock_stop_n_in,
  // Clock phases from the generator core, same domain
  input  wire logic                 host_clock_complement_in,
  input  wire logic                 serial_reference_clock_in,
  input  wire logic                 video_clock_in,
  input  wire logic                 bus_clock_in,
  // Configuration bits
  input  wire clkstop_pkg::host_cfg_s host_cfg_in,
  input  wire logic                 serial_ref_pd_tri_in,
  input  wire logic                 video_pd_tri_in,
  input  wire logic                 free_bus_stoppable_in,
  input  wire logic                 sw_bus_stop_n_in,
  input  wire logic                 select_100mhz_in,
  input  wire logic                 pll_locked_in,
  // Oscillator controls
  output logic                      osc_enable_out,
  output logic                      clocks_stable_out,
  // Clock outputs
  output clkstop_pkg::diff_pair_s [NUM_HOST-1:0] host_pair_out,
  output clkstop_pkg::diff_pair_s  serial_ref_pair_out,
  output clkstop_pkg::diff_pair_s  video_pair_out,
  output logic                      shared_video_ref_output_out,
  output logic [NUM_BUS-1:0]        bus_clock_out,
  output logic                      free_running_bus_clock_out
);

  import clkstop_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic             pin_sync;        // Synchronised shared pin
  logic             host_stop_sync;  // Synchronised host stop, active low
  logic             bus_stop_sync;   // Synchronised bus stop, active low
  logic             hc_prev_r;       // Complement clock, previous level
  logic             hc_rise;         // Complement clock rising strobe
  logic             hc_fall;         // Complement clock falling strobe
  logic             bus_prev_r;      // Bus clock previous level
  logic             bus_rise;        // Bus clock rising strobe
  logic             bus_fall;        // Bus clock falling strobe
  logic             pd_confirmed;    // Power-down seen on two edges
  logic             host_stop_conf;  // Host stop seen on two edges, low
  pwr_state_e       pwr_r;           // Power sequencer state
  pwr_state_e       pwr_nxt;
  logic [CNT_W-1:0] cnt_r;           // Park and lock timers
  logic             pd_park_r;       // Outputs are parked by power-down
  logic             host_park_r;     // Host outputs held by stop
  logic             bus_park_r;      // Bus outputs held by stop
  logic             bus_stop_req;    // Combined bus stop request
  logic [2:0]       hc_fall_cnt_r;   // Complement falls since stop seen

  // Pick the parked level of a pair from its tri-state bit
  function automatic diff_pair_s park_level(input logic tri_bit);
    park_level = tri_bit ? diff_pair_s'(LEG_BOTH_LO)
                         : diff_pair_s'(LEG_TRUE_HI);
  endfunction

  // A running pair from one phase
  function automatic diff_pair_s run_level(input logic phase);
    run_level = '{true_leg: phase, comp_leg: ~phase};
  endfunction

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  two_flop_sync #(.RESET_VAL(1'b0)) u_sync_pin (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (powergood_powerdown_pin_in),
    .sync_out   (pin_sync)
  );

  two_flop_sync #(.RESET_VAL(1'b1)) u_sync_host (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (host_clock_stop_n_in),
    .sync_out   (host_stop_sync)
  );

  two_flop_sync #(.RESET_VAL(1'b1)) u_sync_bus (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (bus_clock_stop_n_in),
    .sync_out   (bus_stop_sync)
  );

  // ------------------------------------------------------------------
  // Edge strobes of the complement and bus clocks
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hc_prev_r  <= 1'b0;
      bus_prev_r <= 1'b0;
    end else begin
      hc_prev_r  <= host_clock_complement_in;
      bus_prev_r <= bus_clock_in;
    end
  end

  assign hc_rise  = host_clock_complement_in & ~hc_prev_r;
  assign hc_fall  = ~host_clock_complement_in & hc_prev_r;
  assign bus_rise = bus_clock_in & ~bus_prev_r;
  assign bus_fall = ~bus_clock_in & bus_prev_r;

  // ------------------------------------------------------------------
  // Two-edge qualification on the complement clock
  // ------------------------------------------------------------------
  // Power-down is only meaningful once the pin has become the request
  // input, so the sampler sees the pin only outside the power-good phase.
  edge_sampler #(.RESET_VAL(1'b0)) u_pd_sample (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .strobe_in     (hc_rise),
    .level_in      (pin_sync && pwr_r != PWR_WAIT_GOOD),
    .confirmed_out (pd_confirmed)
  );

  edge_sampler #(.RESET_VAL(1'b0)) u_host_sample (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .strobe_in     (hc_rise),
    .level_in      (~host_stop_sync),
    .confirmed_out (host_stop_conf)
  );

  // ------------------------------------------------------------------
  // Power sequencer next state
  // ------------------------------------------------------------------
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      PWR_WAIT_GOOD: begin
        // Power-good seen high: pin now acts as power-down
        if (pin_sync) begin
          pwr_nxt = PWR_LOCKING;
        end
      end
      PWR_RUN: begin
        if (pd_confirmed) begin
          pwr_nxt = PWR_PARKING;
        end
      end
      PWR_PARKING: begin
        // Oscillators stay on until every output is parked
        if (pd_park_r && cnt_r >= CNT_W'(PD_ENTRY_PERIODS)) begin
          pwr_nxt = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (!pin_sync) begin
          pwr_nxt = PWR_LOCKING;
        end
      end
      PWR_LOCKING: begin
        // Release all outputs together once locked, bounded by the timer
        if (pll_locked_in || cnt_r >= CNT_W'(STABLE_CNT - 1)) begin
          pwr_nxt = PWR_RUN;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Power sequencer state
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pwr_r <= PWR_WAIT_GOOD;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Timer: counts complement falls while parking, cycles while locking
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
    end else if (pwr_r != pwr_nxt) begin
      cnt_r <= '0;
    end else if (pwr_r == PWR_LOCKING) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end else if (pwr_r == PWR_PARKING && hc_fall) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Power-down park flag, taken on a complement falling edge
  // ------------------------------------------------------------------
  // Parking on the falling edge avoids a short low pulse on host pairs that park with the true leg high.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pd_park_r <= 1'b1;
    end else if (pwr_r == PWR_PARKING && hc_fall) begin
      pd_park_r <= 1'b1;
    end else if (pwr_r == PWR_RUN) begin
      pd_park_r <= 1'b0;
    end else if (pwr_r == PWR_LOCKING && pwr_nxt == PWR_RUN) begin
      pd_park_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Host stop: wait one complement fall, then park on the next fall
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hc_fall_cnt_r <= '0;
      host_park_r   <= 1'b0;
    end else if (!host_stop_conf) begin
      hc_fall_cnt_r <= '0;
      // Release on a falling edge: first pulse is full width
      if (hc_fall) begin
        host_park_r <= 1'b0;
      end
    end else if (hc_fall) begin
      if (hc_fall_cnt_r >= 3'(STOP_MIN_PERIODS - 1)) begin
        host_park_r <= 1'b1;
      end else begin
        hc_fall_cnt_r <= hc_fall_cnt_r + 3'd1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Bus stop: pin and software bit, applied on a bus clock fall
  // ------------------------------------------------------------------
  assign bus_stop_req = ~bus_stop_sync | ~sw_bus_stop_n_in;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_park_r <= 1'b0;
    end else if (bus_fall) begin
      bus_park_r <= bus_stop_req;
    end
  end

  // ------------------------------------------------------------------
  // Oscillator enable and stable indication
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_enable_out    <= 1'b1;
      clocks_stable_out <= 1'b0;
    end else begin
      osc_enable_out    <= (pwr_nxt != PWR_DOWN);
      clocks_stable_out <= (pwr_nxt == PWR_RUN);
    end
  end

  // ------------------------------------------------------------------
  // Output drive, registered
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      host_pair_out               <= '0;
      serial_ref_pair_out         <= '0;
      video_pair_out              <= '0;
      shared_video_ref_output_out <= 1'b0;
      bus_clock_out               <= '0;
      free_running_bus_clock_out  <= 1'b0;
    end else if (pd_park_r) begin
      // Tri-stated pairs park with both legs low, others with the true leg high
      for (int i = 0; i < NUM_HOST; i++) begin
        host_pair_out[i] <= park_level(host_cfg_in.pd_tri[i]);
      end
      serial_ref_pair_out         <= park_level(serial_ref_pd_tri_in);
      video_pair_out              <= park_level(video_pd_tri_in);
      shared_video_ref_output_out <= 1'b0;
      bus_clock_out               <= '0;
      free_running_bus_clock_out  <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_HOST; i++) begin
        if (host_park_r && host_cfg_in.stoppable[i]) begin
          host_pair_out[i] <=
            park_level(host_cfg_in.stop_tri[i]);
        end else begin
          host_pair_out[i] <= run_level(~host_clock_complement_in);
        end
      end
      serial_ref_pair_out <= run_level(serial_reference_clock_in);
      video_pair_out      <= run_level(video_clock_in);
      shared_video_ref_output_out <= select_100mhz_in ?
        serial_reference_clock_in : video_clock_in;
      bus_clock_out <= bus_park_r ? '0 : {NUM_BUS{bus_clock_in}};
      // Free-running output ignores stop unless made stoppable
      free_running_bus_clock_out <=
        (bus_park_r && free_bus_stoppable_in) ?
        1'b0 : bus_clock_in;
    end
  end

endmodule // clock_stop_powerdown_control

// File: clkstop_pkg.sv
/*
  Package for the clock stop and power-down control block: timing counts,
  widths, power sequencer state type and grouped carrier structs.
  Assumes a 100 MHz system clock that runs whenever the block is powered.
*/
package clkstop_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned STABLE_TIME_US       = 1800;  // 1.8 ms, longest
  localparam int unsigned DRIVE_HIGH_TIME_US   = 300;   // Longest
  localparam int unsigned PD_ENTRY_PERIODS     = 4;     // Longest, periods
  localparam int unsigned STOP_MIN_PERIODS     = 2;
  localparam int unsigned STOP_MAX_PERIODS     = 6;
  localparam int unsigned RESUME_MAX_PERIODS   = 2;
  localparam int unsigned STABLE_CYCLES        =
    (STABLE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DRIVE_HIGH_CYCLES    =
    (DRIVE_HIGH_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CYCLES          = DRIVE_HIGH_CYCLES;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int unsigned NUM_HOST     = 3;
  localparam int unsigned NUM_BUS      = 4;
  localparam int unsigned CNT_W        = 24;
  localparam logic        SW_STOP_RST  = 1'b1;  // Software stop deasserted
  localparam logic [1:0]  LEG_TRUE_HI  = 2'b10; // {true, complement}
  localparam logic [1:0]  LEG_BOTH_LO  = 2'b00;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_WAIT_GOOD,
    PWR_RUN,
    PWR_PARKING,
    PWR_DOWN,
    PWR_LOCKING
  } pwr_state_e;

  // Host differential pair configuration
  typedef struct packed {
    logic [NUM_HOST-1:0] stoppable;   // 1 = stopped by host stop
    logic [NUM_HOST-1:0] stop_tri;    // 1 = both legs low when stopped
    logic [NUM_HOST-1:0] pd_tri;      // 1 = both legs low in power-down
  } host_cfg_s;

  // Differential pair legs
  typedef struct packed {
    logic true_leg;
    logic comp_leg;
  } diff_pair_s;

endpackage : clkstop_pkg

// File: two_flop_sync.sv
/*
  Two flip-flop level synchroniser.
  Assumes the input is asynchronous to clk_sys_in; the first stage feeds
  only the second.
*/
`timescale 1ns/1ps
module two_flop_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;  // First stage, read by the second only

  // ------------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // two_flop_sync

// File: edge_sampler.sv
/*
  Samples a level on each rising edge of a strobed clock enable and reports
  it confirmed once two consecutive strobes agree.
  Assumes strobe_in is a one-cycle pulse in the clk_sys_in domain.
*/
`timescale 1ns/1ps
module edge_sampler #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  // Sampling
  input  wire logic strobe_in,
  input  wire logic level_in,
  output logic      confirmed_out
);

  logic first_r;  // Value taken at the previous strobe

  // ------------------------------------------------------------------
  // Two consecutive strobes must see the same level
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      first_r       <= RESET_VAL;
      confirmed_out <= RESET_VAL;
    end else if (strobe_in) begin
      first_r <= level_in;
      if (first_r == level_in) begin
        confirmed_out <= level_in;
      end
    end
  end

endmodule // edge_sampler

// File: clkstop_checker.sv
/*
  Checker for the clock stop and power-down block, bound to its ports.
  Assumes bus phase period 8 and complement period at most 14 cycles.
*/
`timescale 1ns/1ps
module clkstop_checker (
  // -------------------------------------------------------------
  // Watched ports
  // -------------------------------------------------------------
  input wire logic                  clk_sys_in,
  input wire logic                  resetn_in,
  input wire logic                  host_clock_stop_n_in,
  input wire logic                  bus_clock_stop_n_in,
  input wire logic                  serial_reference_clock_in,
  input wire logic                  video_clock_in,
  input wire logic                  bus_clock_in,
  input wire clkstop_pkg::host_cfg_s host_cfg_in,
  input wire logic                  serial_ref_pd_tri_in,
  input wire logic                  video_pd_tri_in,
  input wire logic                  free_bus_stoppable_in,
  input wire logic                  sw_bus_stop_n_in,
  input wire logic                  select_100mhz_in,
  input wire logic                  osc_enable_out,
  input wire logic                  clocks_stable_out,
  input wire clkstop_pkg::diff_pair_s [clkstop_pkg::NUM_HOST-1:0]
                                    host_pair_out,
  input wire clkstop_pkg::diff_pair_s serial_ref_pair_out,
  input wire clkstop_pkg::diff_pair_s video_pair_out,
  input wire logic                  shared_video_ref_output_out,
  input wire logic [3:0]            bus_clock_out,
  input wire logic                  free_running_bus_clock_out
);
  import clkstop_pkg::*;
  logic       bus_req;     // Pin or software bit asks for a bus stop
  logic [7:0] bus_cnt_r;   // Cycles of bus stop while running
  logic [7:0] host_cnt_r;  // Cycles of host stop while running
  assign bus_req = !bus_clock_stop_n_in || !sw_bus_stop_n_in;
  // Restart outside run: a stop left from power-down never settles
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) bus_cnt_r <= 8'h00;
    else if (!bus_req || !clocks_stable_out) bus_cnt_r <= 8'h00;
    else if (bus_cnt_r != 8'hff) bus_cnt_r <= bus_cnt_r + 8'h01;
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) host_cnt_r <= 8'h00;
    else if (host_clock_stop_n_in || !clocks_stable_out) host_cnt_r <= 8'h00;
    else if (host_cnt_r != 8'hff) host_cnt_r <= host_cnt_r + 8'h01;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  pd_single_low_a: assert property (
    !osc_enable_out |-> bus_clock_out == 4'h0 && !free_running_bus_clock_out
    && !shared_video_ref_output_out) else $error("pd output high");
  pd_ref_park_a: assert property (!osc_enable_out |->
    serial_ref_pair_out == (serial_ref_pd_tri_in ? LEG_BOTH_LO : LEG_TRUE_HI))
    else $error("ref pair not parked");
  pd_video_park_a: assert property (!osc_enable_out |->
    video_pair_out == (video_pd_tri_in ? LEG_BOTH_LO : LEG_TRUE_HI))
    else $error("video pair not parked");
  pd_host_park_a: assert property (!osc_enable_out |->
    host_pair_out[0] == (host_cfg_in.pd_tri[0] ? LEG_BOTH_LO : LEG_TRUE_HI))
    else $error("host pair not parked");
  stable_osc_on_a: assert property (
    clocks_stable_out |-> osc_enable_out) else $error("stable off");
  shared_select_a: assert property (
    clocks_stable_out && $past(clocks_stable_out) |->
    shared_video_ref_output_out == $past(select_100mhz_in ?
    serial_reference_clock_in : video_clock_in)) else $error("shared wrong");
  free_bus_runs_a: assert property (
    !free_bus_stoppable_in && clocks_stable_out && $past(clocks_stable_out)
    |-> free_running_bus_clock_out == $past(bus_clock_in))
    else $error("free stopped");
  bus_stop_low_a: assert property (bus_cnt_r >= 8'h0e |->
    bus_clock_out == 4'h0) else $error("bus runs");
  bus_resume_a: assert property ($fell(bus_req) && clocks_stable_out
    |-> ##[1:24] bus_clock_out != 4'h0) else $error("no bus resume");
  host_stop_park_a: assert property (
    host_cnt_r >= 8'h46 && host_cfg_in.stoppable[0] |-> host_pair_out[0] ==
    (host_cfg_in.stop_tri[0] ? LEG_BOTH_LO : LEG_TRUE_HI))
    else $error("host not stopped");
  pd_seen_c: cover property (!osc_enable_out);
  bus_stop_c: cover property (bus_cnt_r == 8'h0e);
  host_stop_c: cover property (host_cnt_r == 8'h46);
endmodule // clkstop_checker

bind clock_stop_powerdown_control clkstop_checker u_chk (.*);

// File: clkstop_partner.sv
/*
  Power-management partner: generator phases, the power-down pin and the two stop pins.
  Assumes bench requests change just after a rising clock edge.
*/
`timescale 1ns/1ps
module clkstop_partner (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  // Requests from the bench
  input  wire logic [3:0] cpu_half_in,       // Complement half period
  input  wire logic       pd_req_in,
  input  wire logic       host_stop_req_in,
  input  wire logic       bus_stop_req_in,
  // Phases and pins
  output logic            comp_out,
  output logic [2:0]      phase_out,         // {bus, video, ref}
  output logic            pin_out,
  output logic            host_stop_n_out,
  output logic            bus_stop_n_out
);
  // -------------------------------------------------------------
  // Phases
  // -------------------------------------------------------------
  logic [2:0] cnt_r;   // Free count: bus period 8, ref 4, video 2
  logic [3:0] half_r;  // Complement half period count
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) cnt_r <= 3'h0;
    else cnt_r <= cnt_r + 3'h1;
  end
  assign phase_out = {cnt_r[2], cnt_r[0], cnt_r[1]};
  // A >= keeps a shorter half period from stalling
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_r <= 4'h0;
      comp_out <= 1'b0;
    end else if (half_r + 4'h1 >= cpu_half_in) begin
      half_r <= 4'h0;
      comp_out <= ~comp_out;
    end else half_r <= half_r + 4'h1;
  end
  // Pins follow requests one edge later
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_out <= 1'b0;
      host_stop_n_out <= 1'b1;
      bus_stop_n_out <= 1'b1;
    end else begin
      pin_out <= pd_req_in;
      host_stop_n_out <= ~host_stop_req_in;
      bus_stop_n_out <= ~bus_stop_req_in;
    end
  end
endmodule // clkstop_partner

// File: tb_top.sv
/*
  Bench for the clock stop block: partner, design and scenario tasks.
  Assumes the checker is bound to the design from its own file.
*/
`timescale 1ns/1ps
module tb_top;
  import clkstop_pkg::*;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic clk, rstn, pd_req, hs_req, bs_req, comp, pin, hs_n, bs_n;
  logic sref_tri, vid_tri, free_stop, sw_n, sel, lock;
  logic osc, stable, shared, free;
  logic [3:0] half, bus_o;
  logic [2:0] ph;
  host_cfg_s cfg;
  diff_pair_s [NUM_HOST-1:0] host_o;
  diff_pair_s sref_o, vid_o;
  int mismatches, check_count;
  clkstop_partner u_partner (.clk_sys_in(clk), .resetn_in(rstn),
    .cpu_half_in(half), .pd_req_in(pd_req), .host_stop_req_in(hs_req),
    .bus_stop_req_in(bs_req), .comp_out(comp), .phase_out(ph),
    .pin_out(pin), .host_stop_n_out(hs_n), .bus_stop_n_out(bs_n));
  // Short stable count keeps each power-up to a few dozen cycles
  clock_stop_powerdown_control #(.STABLE_CNT(50)) DUT (
    .clk_sys_in(clk), .resetn_in(rstn), .powergood_powerdown_pin_in(pin),
    .host_clock_stop_n_in(hs_n), .bus_clock_stop_n_in(bs_n),
    .host_clock_complement_in(comp), .serial_reference_clock_in(ph[0]),
    .video_clock_in(ph[1]), .bus_clock_in(ph[2]), .host_cfg_in(cfg),
    .serial_ref_pd_tri_in(sref_tri), .video_pd_tri_in(vid_tri),
    .free_bus_stoppable_in(free_stop), .sw_bus_stop_n_in(sw_n),
    .select_100mhz_in(sel), .pll_locked_in(lock), .osc_enable_out(osc),
    .clocks_stable_out(stable), .host_pair_out(host_o),
    .serial_ref_pair_out(sref_o), .video_pair_out(vid_o),
    .shared_video_ref_output_out(shared), .bus_clock_out(bus_o),
    .free_running_bus_clock_out(free));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog, run needs under 30 us
  initial begin
    #200us;
    mismatches++;
    results();
  end
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t mismatch: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [1:0] park(input logic tri_bit);
    return tri_bit ? LEG_BOTH_LO : LEG_TRUE_HI;
  endfunction
  // Output must show both levels within 16 cycles
  task automatic toggles(input int which);
    logic hi, lo;
    logic [4:0] v;
    hi = 1'b0;
    lo = 1'b0;
    repeat (16) begin
      tick();
      v = {sref_o.true_leg, host_o[0].true_leg, host_o[1].true_leg, free,
        bus_o[0]};
      hi |= v[which];
      lo |= ~v[which];
    end
    check({7'h00, hi & lo}, 8'h01);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_powerup();
    repeat (30) tick();
    check({7'h00, stable}, 8'h00);
    pd_req = 1'b1;
    repeat (4) tick();
    pd_req = 1'b0;
    lock = 1'b1;
    for (int i = 0; i < 100 && stable !== 1'b1; i++) tick();
    check({7'h00, stable}, 8'h01);
    toggles(0);
    $display("test powerup done");
  endtask
  task automatic t_shared();
    logic e;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      tick();
      repeat (8) begin
        e = sel ? ph[0] : ph[1];
        tick();
        check({7'h00, shared}, {7'h00, e});
      end
    end
    $display("test shared done");
  endtask
  task automatic t_host_stop();
    hs_req = 1'b1;
    repeat (70) tick();
    check({6'h00, host_o[0]}, {6'h00, park(1'b1)});
    check({6'h00, host_o[2]}, {6'h00, park(1'b0)});
    toggles(2);
    hs_req = 1'b0;
    repeat (24) tick();
    toggles(3);
    $display("test host stop done");
  endtask
  task automatic t_bus_stop();
    bs_req = 1'b1;
    repeat (16) tick();
    check({4'h0, bus_o}, 8'h00);
    toggles(1);
    bs_req = 1'b0;
    repeat (20) tick();
    toggles(0);
    free_stop = 1'b1;
    sw_n = 1'b0;
    repeat (16) tick();
    check({3'h0, free, bus_o}, 8'h00);
    sw_n = 1'b1;
    repeat (20) tick();
    toggles(1);
    free_stop = 1'b0;
    $display("test bus stop done");
  endtask
  task automatic t_powerdown();
    for (int f = 0; f < 2; f++) begin
      half = f[0] ? 4'h7 : 4'h4;
      sref_tri = ~f[0];
      vid_tri = f[0];
      repeat (20) tick();
      pd_req = 1'b1;
      for (int i = 0; i < 200 && osc !== 1'b0; i++) tick();
      check({7'h00, osc}, 8'h00);
      check({2'h0, shared, free, bus_o}, 8'h00);
      check({2'h0, sref_o, vid_o, host_o[1]}, {2'h0, park(sref_tri),
        park(vid_tri), park(1'b0)});
      check({6'h00, host_o[0]}, {6'h00, park(1'b1)});
      lock = 1'b0;
      pd_req = 1'b0;
      for (int i = 0; i < 80 && stable !== 1'b1; i++) tick();
      check({7'h00, stable}, 8'h01);
      toggles(4);
      lock = 1'b1;
    end
    $display("test powerdown done");
  endtask
  initial begin
    rstn = 1'b0;
    pd_req = 1'b0;
    hs_req = 1'b0;
    bs_req = 1'b0;
    half = 4'h4;
    sref_tri = 1'b1;
    vid_tri = 1'b0;
    free_stop = 1'b0;
    sw_n = 1'b1;
    sel = 1'b0;
    lock = 1'b0;
    cfg = '{stoppable: 3'h5, stop_tri: 3'h1, pd_tri: 3'h5};
    repeat (20) tick();
    rstn = 1'b1;
    t_powerup();
    t_shared();
    t_host_stop();
    t_bus_stop();
    t_powerdown();
    results();
  end
endmodule // tb_top
